// [hdl/ptpc_top.sv]
// Functional notes
// - six identical units record time, seq, identity
// - slave: sync on receive, delay_req transmit
// - master: delay_req on receive, sync transmit
// - other message types never capture
// - master select per port, independent
// - phy ports: from phy is receive
// - host port: same sense, from fabric is receive
// - latch clock at first bit after sfd
// - fixed pipeline lag stays deterministic
// - commit stamp only after type and fcs
// - commit seq id and identity too
// - each capture sets its event flag
// - non-whole-octet frames never capture
// - lock holds captures until flag cleared
// - separate rx and tx lock bits
// - gpio lock holds capture while flagged
// - gpio inputs capture, outputs on compare
// - qualify by enabled ptp destination address
// - control byte 32 selects message type
// - udp payload at 42 or 46
//
// top of the time stamp capture block with wishbone register access
// assumes mii streams and gpio pins are asynchronous, protocol clock on ref_clk_in
`timescale 1ns/100ps
module ptpc_top
  import ptpc_pkg::*;
(
  input  wire logic               ref_clk_in,       // 40 MHz clock
  input  wire logic               sys_rst_in,       // sync reset, high
  input  wire logic [63:0]        ptp_time_in,      // protocol clock
  input  wire logic [2:0]         phy_rx_dv_in,     // from phy / from fabric (port0)
  input  wire logic [11:0]        phy_rx_nib_in,    // 4 bits per port
  input  wire logic [2:0]         phy_tx_en_in,     // to phy / to fabric (port0)
  input  wire logic [11:0]        phy_tx_nib_in,    // 4 bits per port
  input  wire logic [1:0]         gpio_in,          // gpio pin levels
  input  wire logic [1:0]         gpio_dir_out_in,  // 1 = pin is output
  input  wire logic [1:0]         target_evt_in,    // compare event pulse
  output logic      [1:0]         gpio_out,         // gpio drive level
  output logic      [1:0]         gpio_oe_out,      // gpio output enable
  input  wire logic               wb_cyc_i,         // wishbone cycle
  input  wire logic               wb_stb_i,         // wishbone strobe
  input  wire logic               wb_we_i,          // write
  input  wire logic [PTPC_AW-1:0] wb_adr_i,         // byte address
  input  wire logic [3:0]         wb_sel_i,         // byte enables
  input  wire logic [31:0]        wb_dat_i,         // write data
  output logic      [31:0]        wb_dat_o,         // read data
  output logic                    wb_ack_o          // acknowledge
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [31:0] pin_s1_q;
  logic [31:0] pin_s2_q;
  logic [1:0]  gp_prev_q;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pin_s1_q  <= '0;
      pin_s2_q  <= '0;
      gp_prev_q <= '0;
    end else begin
      pin_s1_q  <= {gpio_in, phy_tx_nib_in, phy_tx_en_in, phy_rx_nib_in, phy_rx_dv_in};
      pin_s2_q  <= pin_s1_q;
      gp_prev_q <= pin_s2_q[31:30];
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0]  cfg_q, cfg_d;
  logic [7:0]   sts_q, sts_d;
  logic [47:0]  aux_q, aux_d;
  logic [63:0]  cap_t_q [6];
  logic [15:0]  cap_s_q [6];
  logic [79:0]  cap_i_q [6];
  logic [63:0]  gp_t_q  [2];
  logic [5:0]   hit;
  logic [63:0]  u_t     [6];
  logic [15:0]  u_s     [6];
  logic [79:0]  u_i     [6];
  logic [5:0]   take;
  logic [1:0]   gp_take;
  logic         wb_req;
  logic         wb_wr;
  logic [7:0]   sts_clr;
  logic [1:0]   gp_q;
  logic [1:0]   gp_oe_q;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;

  // ------------------------------------------------------------
  // capture units, index 2*port+dir (dir 0 = receive)
  // ------------------------------------------------------------
  for (genvar p = 0; p < PTPC_PORTS; p++) begin : g_port
    for (genvar d = 0; d < 2; d++) begin : g_dir
      // rx pins carry from-phy on ports 1,2 and from-fabric on port0,
      // so both already mean receive, no swap here
      localparam int SRC = d;
      logic       dv;
      logic [3:0] nb;
      logic       ms;
      assign ms = cfg_q[PTPC_CFG_MS + p];
      assign dv = (SRC == 0) ? pin_s2_q[p] : pin_s2_q[15 + p];
      assign nb = (SRC == 0) ? pin_s2_q[3 + 4*p +: 4] : pin_s2_q[18 + 4*p +: 4];
      ptpc_unit u_unit (
        .ref_clk_in   (ref_clk_in),
        .sys_rst_in   (sys_rst_in),
        .dv_in        (dv),
        .nib_in       (nb),
        .ptp_time_in  (ptp_time_in),
        .want_sync_in ((d == 0) ? !ms : ms),
        .mac_en_in    (cfg_q[PTPC_CFG_MACEN + 5*p +: 5]),
        .aux_mac_in   (aux_q),
        .hit_out      (hit[2*p+d]),
        .time_out     (u_t[2*p+d]),
        .seq_out      (u_s[2*p+d]),
        .src_out      (u_i[2*p+d])
      );
      // lock while flag set
      assign take[2*p+d] = hit[2*p+d] &&
                           !(sts_q[2*p+d] && cfg_q[(d == 0 ? PTPC_CFG_LKRX : PTPC_CFG_LKTX) + p]);
    end
  end

  for (genvar g = 0; g < PTPC_GPIOS; g++) begin : g_gpio
    // rising edge on input-mode pin captures; lock per pin
    assign gp_take[g] = !gpio_dir_out_in[g] && pin_s2_q[30+g] && !gp_prev_q[g] &&
                        !(sts_q[PTPC_STS_GP+g] && cfg_q[PTPC_CFG_LKGP+g]);
  end

  always_comb begin
    sts_clr = '0;
    cfg_d   = cfg_q;
    aux_d   = aux_q;
    if (wb_wr && wb_adr_i == PTPC_REG_STS && wb_sel_i[0]) sts_clr = wb_dat_i[7:0];
    if (wb_wr && wb_adr_i == PTPC_REG_CFG) begin
      for (int b = 0; b < 4; b++) if (wb_sel_i[b]) cfg_d[8*b +: 8] = wb_dat_i[8*b +: 8];
    end
    cfg_d[31:PTPC_CFG_W] = '0;  // unused bits read zero
    if (wb_wr && wb_adr_i == PTPC_REG_AUXHI) begin
      for (int b = 0; b < 2; b++) if (wb_sel_i[b]) aux_d[32+8*b +: 8] = wb_dat_i[8*b +: 8];
    end
    if (wb_wr && wb_adr_i == PTPC_REG_AUXLO) begin
      for (int b = 0; b < 4; b++) if (wb_sel_i[b]) aux_d[8*b +: 8] = wb_dat_i[8*b +: 8];
    end
    // set wins over clear
    sts_d = (sts_q & ~sts_clr) | {gp_take, take};
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  logic [31:0] rd;
  logic [2:0]  ci;
  logic [3:0]  cw;
  always_comb begin
    rd = '0;
    ci = 3'(wb_adr_i[6:4] - 3'h4);
    cw = wb_adr_i[5:2];
    if (wb_adr_i == PTPC_REG_CFG) rd = cfg_q;
    else if (wb_adr_i == PTPC_REG_STS) rd = {24'h000000, sts_q};
    else if (wb_adr_i == PTPC_REG_AUXHI) rd = {16'h0000, aux_q[47:32]};
    else if (wb_adr_i == PTPC_REG_AUXLO) rd = aux_q[31:0];
    else if (wb_adr_i >= PTPC_REG_CAP0 && wb_adr_i < PTPC_REG_GPIO0) begin
      case (wb_adr_i[3:2])
        2'h0: rd = cap_t_q[ci][63:32];
        2'h1: rd = cap_t_q[ci][31:0];
        2'h2: rd = {cap_s_q[ci], cap_i_q[ci][79:64]};
        default: rd = cap_i_q[ci][63:32];
      endcase
    end else if (wb_adr_i >= PTPC_REG_GPIO0 && wb_adr_i < PTPC_REG_GPIO0 + 8'h10) begin
      rd = cw[0] ? gp_t_q[cw[1]][31:0] : gp_t_q[cw[1]][63:32];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cfg_q    <= PTPC_CFG_RST;
      sts_q    <= '0;
      aux_q    <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      gp_q     <= '0;
      gp_oe_q  <= '0;
      for (int k = 0; k < 6; k++) begin
        cap_t_q[k] <= '0;
        cap_s_q[k] <= '0;
        cap_i_q[k] <= '0;
      end
      for (int k = 0; k < 2; k++) gp_t_q[k] <= '0;
    end else begin
      cfg_q    <= cfg_d;
      sts_q    <= sts_d;
      aux_q    <= aux_d;
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd : '0;
      gp_oe_q  <= gpio_dir_out_in;
      gp_q     <= gp_q ^ (gpio_dir_out_in & target_evt_in);
      for (int k = 0; k < 6; k++) begin
        if (take[k]) begin
          cap_t_q[k] <= u_t[k];
          cap_s_q[k] <= u_s[k];
          cap_i_q[k] <= u_i[k];
        end
      end
      for (int k = 0; k < 2; k++) if (gp_take[k]) gp_t_q[k] <= ptp_time_in;
    end
  end

  assign gpio_out    = gp_q;
  assign gpio_oe_out = gp_oe_q;
endmodule : ptpc_top

// [hdl/ptpc_pkg.sv]
// package for the per-port time stamp capture block
// assumes one 40 MHz clock domain, wishbone classic register access
package ptpc_pkg;
  localparam int          PTPC_PORTS      = 3;
  localparam int          PTPC_GPIOS      = 2;
  localparam int          PTPC_AW         = 8;
  localparam int          PTPC_CLK_MHZ    = 40;
  // capture path delay figures, in ns, kept for software compensation
  localparam int          PTPC_DLY100_NS  = 30;
  localparam int          PTPC_DLY10_NS   = 120;
  localparam int          PTPC_DLY_TOL_NS = 10;
  localparam int          PTPC_DLY100_CYC = (PTPC_DLY100_NS * PTPC_CLK_MHZ) / 1000;
  // frame byte layout
  localparam logic [10:0] PTPC_UDP_UNTAG  = 11'h02A;  // 42
  localparam logic [10:0] PTPC_UDP_TAG    = 11'h02E;  // 46
  localparam logic [10:0] PTPC_CTRL_OFS   = 11'h020;  // 32
  localparam logic [10:0] PTPC_SEQ_OFS    = 11'h01E;  // 30, seq id
  localparam logic [10:0] PTPC_SRC_OFS    = 11'h016;  // 22, source identity
  localparam logic [10:0] PTPC_TPID_OFS   = 11'h00C;  // 12
  localparam logic [15:0] PTPC_TPID_VLAN  = 16'h8100;
  localparam logic [7:0]  PTPC_MSG_SYNC   = 8'h00;
  localparam logic [7:0]  PTPC_MSG_DREQ   = 8'h01;
  localparam logic [39:0] PTPC_MC_BASE    = 40'h01005E0001;
  localparam logic [7:0]  PTPC_MC_FIRST   = 8'h81;
  localparam logic [31:0] PTPC_CRC_INIT   = 32'hFFFFFFFF;
  localparam logic [31:0] PTPC_CRC_POLY   = 32'hEDB88320;  // reflected polynomial
  localparam logic [31:0] PTPC_CRC_RESID  = 32'hDEBB20E3;  // register after data plus fcs
  localparam logic [3:0]  PTPC_SFD_NIB    = 4'hD;
  localparam logic [7:0]  PTPC_MSG_NONE   = 8'hFF;         // no type byte seen yet
  localparam logic [10:0] PTPC_DA_BYTES   = 11'h006;
  // register byte addresses
  localparam logic [PTPC_AW-1:0] PTPC_REG_CFG   = 8'h00;  // master sel, locks, mac enables
  localparam logic [PTPC_AW-1:0] PTPC_REG_STS   = 8'h04;  // event flags, write 1 clears
  localparam logic [PTPC_AW-1:0] PTPC_REG_AUXHI = 8'h08;
  localparam logic [PTPC_AW-1:0] PTPC_REG_AUXLO = 8'h0C;
  localparam logic [PTPC_AW-1:0] PTPC_REG_CAP0  = 8'h40;  // port x dir: base+0x20*port+0x10*dir
  localparam logic [PTPC_AW-1:0] PTPC_REG_GPIO0 = 8'hA0;
  // config field positions
  localparam int          PTPC_CFG_MS     = 0;   // [2:0] master select per port
  localparam int          PTPC_CFG_LKRX   = 3;   // [5:3]
  localparam int          PTPC_CFG_LKTX   = 6;   // [8:6]
  localparam int          PTPC_CFG_LKGP   = 9;   // [10:9]
  localparam int          PTPC_CFG_MACEN  = 11;  // 5 bits per port [25:11]
  localparam int          PTPC_CFG_W      = PTPC_CFG_MACEN + 5 * PTPC_PORTS;  // used config width
  localparam logic [31:0] PTPC_CFG_RST    = 32'h03FFF800;
  // status layout: bit 2*port = rx, 2*port+1 = tx, 6..7 gpio
  localparam int          PTPC_STS_GP     = 6;
endpackage : ptpc_pkg

// [hdl/ptpc_crc.sv]
// ethernet fcs checker over a nibble stream
// assumes nibbles arrive low nibble first, one per valid cycle
`timescale 1ns/100ps
module ptpc_crc
  import ptpc_pkg::*;
(
  input  wire logic       ref_clk_in,   // system clock
  input  wire logic       clr_in,       // restart at frame start
  input  wire logic       nib_vld_in,   // nibble valid
  input  wire logic [3:0] nib_in,       // data nibble
  output logic            good_out      // residue matches
);
  logic [31:0] crc_q;
  logic [31:0] crc_d;

  always_comb begin
    crc_d = crc_q;
    if (clr_in) begin
      crc_d = PTPC_CRC_INIT;
    end else if (nib_vld_in) begin
      for (int i = 0; i < 4; i++) begin
        crc_d = (crc_d[0] ^ nib_in[i]) ? ((crc_d >> 1) ^ PTPC_CRC_POLY) : (crc_d >> 1);
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    crc_q <= crc_d;
  end

  assign good_out = (crc_q == PTPC_CRC_RESID);
endmodule : ptpc_crc

// [hdl/ptpc_unit.sv]
// one per-port, per-direction capture unit: frame parser, holding register, qualifier
// assumes mii nibble streams already synchronised to ref_clk_in
`timescale 1ns/100ps
module ptpc_unit
  import ptpc_pkg::*;
(
  input  wire logic        ref_clk_in,    // system clock
  input  wire logic        sys_rst_in,    // sync reset
  input  wire logic        dv_in,         // data valid
  input  wire logic [3:0]  nib_in,        // data nibble
  input  wire logic [63:0] ptp_time_in,   // protocol clock
  input  wire logic        want_sync_in,  // qualify sync, else delay_req
  input  wire logic [4:0]  mac_en_in,     // pri, alt1..3, user
  input  wire logic [47:0] aux_mac_in,    // user address
  output logic             hit_out,       // one-cycle qualified capture
  output logic [63:0]      time_out,      // held stamp
  output logic [15:0]      seq_out,       // sequence id
  output logic [79:0]      src_out        // source identity
);
  typedef enum logic [1:0] {PTPC_IDLE, PTPC_PRE, PTPC_DATA} ptpc_st_e;
  ptpc_st_e    st_q, st_d;
  logic [11:0] nc_q, nc_d;
  logic [3:0]  lo_q, lo_d;
  logic [63:0] hold_q, hold_d;
  logic [47:0] da_q, da_d;
  logic        tag_q, tag_d;
  logic [7:0]  typ_q, typ_d;
  logic [15:0] seq_q, seq_d;
  logic [79:0] src_q, src_d;
  logic        crc_good;
  logic        crc_clr;
  logic [10:0] bidx;
  logic [7:0]  byt;
  logic [10:0] udp;
  logic        da_hit;
  logic        ok;

  assign bidx    = nc_q[11:1];
  assign byt     = {nib_in, lo_q};
  assign udp     = tag_q ? PTPC_UDP_TAG : PTPC_UDP_UNTAG;
  assign crc_clr = (st_q != PTPC_DATA);

  ptpc_crc u_crc (
    .ref_clk_in (ref_clk_in),
    .clr_in     (crc_clr),
    .nib_vld_in (st_q == PTPC_DATA && dv_in),
    .nib_in     (nib_in),
    .good_out   (crc_good)
  );

  always_comb begin
    da_hit = mac_en_in[4] && (da_q == aux_mac_in);
    for (int m = 0; m < 4; m++) begin
      if (mac_en_in[m] && da_q == {PTPC_MC_BASE, PTPC_MC_FIRST + 8'(m)}) begin
        da_hit = 1'b1;
      end
    end
    ok = da_hit && (typ_q == (want_sync_in ? PTPC_MSG_SYNC : PTPC_MSG_DREQ));
  end

  always_comb begin
    st_d   = st_q;
    nc_d   = nc_q;
    lo_d   = lo_q;
    hold_d = hold_q;
    da_d   = da_q;
    tag_d  = tag_q;
    typ_d  = typ_q;
    seq_d  = seq_q;
    src_d  = src_q;
    case (st_q)
      PTPC_IDLE: if (dv_in) st_d = PTPC_PRE;
      PTPC_PRE: begin
        if (!dv_in) begin
          st_d = PTPC_IDLE;
        end else if (nib_in == PTPC_SFD_NIB) begin
          st_d   = PTPC_DATA;                                           // sfd seen
          nc_d   = '0;
          typ_d  = PTPC_MSG_NONE;
          tag_d  = 1'b0;
          hold_d = ptp_time_in;
        end
      end
      PTPC_DATA: begin
        if (!dv_in) begin
          st_d = PTPC_IDLE;
        end else begin
          nc_d = nc_q + 12'h001;
          if (!nc_q[0]) begin
            lo_d = nib_in;
          end else begin
            if (bidx < PTPC_DA_BYTES) da_d = {da_q[39:0], byt};
            if (bidx == PTPC_TPID_OFS && byt == PTPC_TPID_VLAN[15:8]) tag_d = 1'b1;
            if (bidx == PTPC_TPID_OFS + 11'h001 && byt != PTPC_TPID_VLAN[7:0]) tag_d = 1'b0;
            if (bidx == udp + PTPC_CTRL_OFS) typ_d = byt;
            if (bidx >= udp + PTPC_SEQ_OFS && bidx < udp + PTPC_CTRL_OFS) seq_d = {seq_q[7:0], byt};
            if (bidx >= udp + PTPC_SRC_OFS && bidx < udp + PTPC_SEQ_OFS) src_d = {src_q[71:0], byt};
          end
        end
      end
      default: st_d = PTPC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_q    <= PTPC_IDLE;
      nc_q    <= '0;
      lo_q    <= '0;
      hold_q  <= '0;
      da_q    <= '0;
      tag_q   <= 1'b0;
      typ_q   <= PTPC_MSG_NONE;
      seq_q   <= '0;
      src_q   <= '0;
      hit_out <= 1'b0;
    end else begin
      st_q    <= st_d;
      nc_q    <= nc_d;
      lo_q    <= lo_d;
      hold_q  <= hold_d;
      da_q    <= da_d;
      tag_q   <= tag_d;
      typ_q   <= typ_d;
      seq_q   <= seq_d;
      src_q   <= src_d;
      // end of frame: good fcs, whole octets, matching type
      hit_out <= (st_q == PTPC_DATA) && !dv_in && !nc_q[0] && crc_good && ok;
    end
  end

  assign time_out = hold_q;
  assign seq_out  = seq_q;
  assign src_out  = src_q;
endmodule : ptpc_unit

// [tb/ptpc_chk.sv]
// checker for ptpc_top: bus handshake, reset quiet, read-only fields, gpio drive
// assumes it is bound into ptpc_top with every port connected by name
`timescale 1ns/100ps
module ptpc_chk
  import ptpc_pkg::*;
(
  input wire logic               ref_clk_in,       // system clock
  input wire logic               sys_rst_in,       // sync reset
  input wire logic [1:0]         gpio_dir_out_in,  // pin direction
  input wire logic [1:0]         target_evt_in,    // compare pulse
  input wire logic [1:0]         gpio_out,         // pin level
  input wire logic [1:0]         gpio_oe_out,      // pin enable
  input wire logic               wb_cyc_i,         // cycle
  input wire logic               wb_stb_i,         // strobe
  input wire logic               wb_we_i,          // write
  input wire logic [PTPC_AW-1:0] wb_adr_i,         // address
  input wire logic [31:0]        wb_dat_o,         // read data
  input wire logic               wb_ack_o          // acknowledge
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_rst_quiet: assert property (disable iff (1'b0) sys_rst_in |=> !wb_ack_o && gpio_oe_out == 2'h0)
    else $error("outputs active after reset");
  a_unmapped_rd: assert property (wb_ack_o && !wb_we_i && wb_adr_i inside {[8'h10:8'h3C]} |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // ----------------------------------------
  // register fields and pins
  // ----------------------------------------
  a_sts_upper: assert property (wb_ack_o && !wb_we_i && wb_adr_i == PTPC_REG_STS |-> wb_dat_o[31:8] == 24'h0)
    else $error("status reads unused bits");
  a_cfg_upper: assert property (wb_ack_o && !wb_we_i && wb_adr_i == PTPC_REG_CFG |-> wb_dat_o[31:26] == 6'h0)
    else $error("config reads unused bits");
  a_gpio_hold: assert property ((target_evt_in == 2'h0 && $stable(gpio_dir_out_in)) [*3] |=> $stable(gpio_out))
    else $error("gpio level moved without event");
  a_oe_dir: assert property ($stable(gpio_dir_out_in) [*3] |-> gpio_oe_out == gpio_dir_out_in)
    else $error("gpio enable differs from direction");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_sts_set: cover property (wb_ack_o && !wb_we_i && wb_adr_i == PTPC_REG_STS && wb_dat_o != 32'h0);
  c_cap_rd: cover property (wb_ack_o && !wb_we_i && wb_adr_i == PTPC_REG_CAP0);
endmodule : ptpc_chk

// [tb/ptpc_mii_src.sv]
// frame source standing in for phys and fabric on six nibble lanes
// assumes the bench calls send on one lane at a time, between clock edges
`timescale 1ns/100ps
module ptpc_mii_src (
  input  wire logic        ref_clk_in,  // system clock
  output logic      [5:0]  dv_out,      // rx lanes 2:0, tx lanes 5:3
  output logic      [23:0] nib_out      // 4 bits per lane
);
  logic [5:0] busy = 6'h0;
  initial begin
    dv_out = 6'h0;
    nib_out = 24'h0;
  end
  // released lanes toggle so stale nibbles never look settled
  always @(posedge ref_clk_in) begin
    for (int l = 0; l < 6; l++) begin
      if (!busy[l]) nib_out[4*l+:4] <= ~nib_out[4*l+:4];
    end
  end
  task automatic send(input int l, input logic [7:0] f[$], input bit odd);
    busy[l] = 1'b1;
    for (int i = 0; i < 16; i++) begin  // preamble then sfd nibble
      @(posedge ref_clk_in);
      dv_out[l] <= 1'b1;
      nib_out[4*l+:4] <= (i == 15) ? 4'hD : 4'h5;
    end
    foreach (f[i]) begin
      for (int h = 0; h < 2; h++) begin  // low nibble first
        @(posedge ref_clk_in);
        nib_out[4*l+:4] <= h ? f[i][7:4] : f[i][3:0];
      end
    end
    if (odd) begin  // stray trailing nibble
      @(posedge ref_clk_in);
      nib_out[4*l+:4] <= 4'h6;
    end
    @(posedge ref_clk_in);
    dv_out[l] <= 1'b0;
    busy[l] = 1'b0;
  endtask : send
endmodule : ptpc_mii_src

// [tb/ptpc_top_tb.sv]
// bench for ptpc_top: message qualification per port, fcs, framing, lock
// assumes the checker and the frame source are compiled before this file
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, a, e); end end
module ptpc_top_tb
  import ptpc_pkg::*;
;
  logic               ref_clk_in = 1'b0;
  logic               sys_rst_in = 1'b1;
  logic [63:0]        ptp_time_in = 64'h0;
  logic               wb_cyc_i = 1'b0;
  logic               wb_stb_i = 1'b0;
  logic               wb_we_i = 1'b0;
  logic [PTPC_AW-1:0] wb_adr_i = '0;
  logic [3:0]         wb_sel_i = 4'hF;
  logic [31:0]        wb_dat_i = 32'h0;
  logic [31:0]        wb_dat_o;
  logic [31:0]        q;
  logic               wb_ack_o;
  logic [5:0]         m_dv;
  logic [23:0]        m_nib;
  logic [1:0]         gp_in = 2'h0, gp_dir = 2'h0, gp_evt = 2'h0, gp_o, gp_oe;
  logic [63:0]        last [6];
  bit                 have [6] = '{default: 1'b0};
  int                 err_total = 0;
  int                 n_tests = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  ptpc_top dut (.ref_clk_in, .sys_rst_in, .ptp_time_in, .phy_rx_dv_in(m_dv[2:0]), .phy_rx_nib_in(m_nib[11:0]),
    .phy_tx_en_in(m_dv[5:3]), .phy_tx_nib_in(m_nib[23:12]), .gpio_in(gp_in), .gpio_dir_out_in(gp_dir),
    .target_evt_in(gp_evt), .gpio_out(gp_o), .gpio_oe_out(gp_oe), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  ptpc_mii_src src (.ref_clk_in, .dv_out(m_dv), .nib_out(m_nib));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic wb(input logic we, input logic [PTPC_AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) begin
      err_total++;
      $display("CHECK FAILED %0t bus timeout", $time);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb
  function automatic logic [31:0] crc(input logic [7:0] f[$]);
    logic [31:0] c;
    c = PTPC_CRC_INIT;
    foreach (f[i]) begin
      c ^= {24'h0, f[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return ~c;
  endfunction : crc
  function automatic void mk(output logic [7:0] f[$], input logic [7:0] msg, da, input bit tag);
    logic [31:0] c;
    f = {8'h01, 8'h00, 8'h5E, 8'h00, 8'h01, da, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
    if (tag) f = {f, PTPC_TPID_VLAN[15:8], PTPC_TPID_VLAN[7:0], 8'h00, 8'h05};
    f = {f, 8'h08, 8'h00};
    while (f.size() < (tag ? 66 : 62)) f.push_back(8'h00);
    repeat (10) f.push_back(8'hA5);
    f = {f, 8'h12, 8'h34, msg, 8'h00};
    c = crc(f);
    f = {f, c[7:0], c[15:8], c[23:16], c[31:24]};
  endfunction : mk
  // one frame on port p, direction d; then flag and capture registers
  task automatic run(input int p, input bit d, input logic [7:0] msg, da, input bit tag, bad, odd, cap, fl);
    logic [7:0]         f[$];
    logic [63:0]        t;
    logic [PTPC_AW-1:0] b;
    int                 l;
    l = p + 3 * d;
    b = PTPC_REG_CAP0 + 8'(32 * p + 16 * d);
    t = {32'h5A5A0000 ^ 32'(n_tests), 32'h0F0F0000 + 32'(n_tests)};
    mk(f, msg, da, tag);
    if (bad) f[20] = f[20] ^ 8'h01;
    ptp_time_in <= t;
    fork
      src.send(l, f, odd);
      begin
        repeat (60) @(posedge ref_clk_in);
        ptp_time_in <= ~t;
      end
    join
    repeat (8) @(posedge ref_clk_in);
    wb(1'b0, PTPC_REG_STS, 32'h0);
    `CHK(q[2*p+d], fl)
    if (cap) last[l] = t;
    if (cap) have[l] = 1'b1;
    if (have[l]) begin
      wb(1'b0, b, 32'h0);
      `CHK(q, last[l][63:32])
      wb(1'b0, b + 8'h04, 32'h0);
      `CHK(q, last[l][31:0])
      wb(1'b0, b + 8'h08, 32'h0);
      `CHK(q[31:16], 16'h1234)
      wb(1'b0, b + 8'h0C, 32'h0);
      `CHK(q, 32'hA5A5A5A5)
    end
  endtask : run
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    wb(1'b0, PTPC_REG_CFG, 32'h0);
    `CHK(q, PTPC_CFG_RST)
    wb(1'b0, PTPC_REG_STS, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b1, 8'h3C, 32'hFFFFFFFF);
    wb(1'b0, 8'h3C, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b1, PTPC_REG_CFG, 32'hFFFFFFFF);
    wb(1'b0, PTPC_REG_CFG, 32'h0);
    `CHK(q, 32'h03FFFFFF)
    for (int p = 0; p < 3; p++) begin
      for (int m = 0; m < 2; m++) begin
        wb(1'b1, PTPC_REG_CFG, PTPC_CFG_RST | 32'(m ? (1 << p) : (7 & ~(1 << p))));
        for (int d = 0; d < 2; d++) begin
          for (int k = 0; k < 5; k++) begin
            bit e;
            e = (8'(k) == ((d ^ m) ? PTPC_MSG_DREQ : PTPC_MSG_SYNC));
            run(p, d[0], 8'(k), 8'h81, 1'b0, 1'b0, 1'b0, e, e);
            wb(1'b1, PTPC_REG_STS, 32'h000000FF);
          end
        end
      end
    end
    wb(1'b1, PTPC_REG_CFG, PTPC_CFG_RST);
    run(1, 1'b0, PTPC_MSG_SYNC, 8'h81, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    run(1, 1'b0, PTPC_MSG_SYNC, 8'h81, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    run(1, 1'b0, PTPC_MSG_SYNC, 8'h85, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    wb(1'b1, PTPC_REG_AUXHI, 32'h00000100);
    wb(1'b1, PTPC_REG_AUXLO, 32'h5E000185);
    run(1, 1'b0, PTPC_MSG_SYNC, 8'h85, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    wb(1'b1, PTPC_REG_STS, 32'h000000FF);
    for (int k = 2; k < 5; k++) begin
      run(2, 1'b0, PTPC_MSG_SYNC, 8'(8'h80 + k), 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
      wb(1'b1, PTPC_REG_STS, 32'h000000FF);
    end
    wb(1'b1, PTPC_REG_CFG, 32'h0);
    run(0, 1'b0, PTPC_MSG_SYNC, 8'h81, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    wb(1'b1, PTPC_REG_CFG, PTPC_CFG_RST | (32'h1 << (PTPC_CFG_LKRX + 1)));
    run(1, 1'b0, PTPC_MSG_SYNC, 8'h81, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    run(1, 1'b0, PTPC_MSG_SYNC, 8'h81, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    run(1, 1'b1, PTPC_MSG_DREQ, 8'h81, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    run(1, 1'b1, PTPC_MSG_DREQ, 8'h81, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    wb(1'b1, PTPC_REG_STS, 32'h00000004);
    run(1, 1'b0, PTPC_MSG_SYNC, 8'h81, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    // gpio pin 0 captures on a rising edge, then its lock holds the value
    wb(1'b1, PTPC_REG_CFG, PTPC_CFG_RST | (32'h1 << PTPC_CFG_LKGP));
    ptp_time_in <= 64'h1122334455667788;
    gp_in <= 2'h1;
    repeat (6) @(posedge ref_clk_in);
    ptp_time_in <= 64'h0;
    gp_in <= 2'h0;
    repeat (6) @(posedge ref_clk_in);
    gp_in <= 2'h1;
    repeat (6) @(posedge ref_clk_in);
    wb(1'b0, PTPC_REG_STS, 32'h0);
    `CHK(q[PTPC_STS_GP +: 2], 2'h1)
    wb(1'b0, PTPC_REG_GPIO0, 32'h0);
    `CHK(q, 32'h11223344)
    wb(1'b0, PTPC_REG_GPIO0 + 8'h04, 32'h0);
    `CHK(q, 32'h55667788)
    // pin 1 as output toggles on its compare event, input pin 0 ignores it
    gp_dir <= 2'h2;
    repeat (3) @(posedge ref_clk_in);
    gp_evt <= 2'h3;
    @(posedge ref_clk_in);
    gp_evt <= 2'h0;
    repeat (2) @(posedge ref_clk_in);
    `CHK({gp_oe, gp_o}, 4'hA)
    complete_run();
  end
  initial begin
    #1500000;
    err_total++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    complete_run();
  end
endmodule : ptpc_top_tb
bind ptpc_top ptpc_chk u_chk (.ref_clk_in, .sys_rst_in, .gpio_dir_out_in, .target_evt_in, .gpio_out,
  .gpio_oe_out, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o);
